// >>> asp_defines.svh
// Offsets, reset values, field codes and frame counts of the serial configuration port
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// Register bus byte offsets
`define ASP_OFF_CONFIG     32'h0000_0000
`define ASP_OFF_RESULT     32'h0000_0004
`define ASP_OFF_CONTROL    32'h0000_0008
`define ASP_OFF_STATUS     32'h0000_000C

// Reset values
`define ASP_CFG_RESET      8'h01
`define ASP_RESULT_RESET   16'h0000

// Register access command: fixed pattern of command bits 5..0
`define ASP_CMD_PATTERN    6'h14

// Frame bit counts
`define ASP_CMD_LAST       5'h07
`define ASP_DATA_LAST      5'h0F
`define ASP_IN_BITS        5'h10
`define ASP_RESULT_BITS    5'h10
`define ASP_RESULT_STATUS  5'h16

// Bus responses
`define ASP_RESP_OKAY      2'h0
`define ASP_RESP_SLVERR    2'h2

`endif

// >>> asp_pkg.sv
// Types shared by the serial configuration port modules
package asp_pkg;

	typedef struct packed {
		logic [2:0] reserved;
		logic       statusEn;
		logic       spanComp;
		logic       highZ;
		logic       fastRead;
		logic       ovFlagN;
	} asp_cfg_t;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} asp_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} asp_axil_rsp_t;

	typedef struct packed {
		logic stage1;
		logic stage2;
	} asp_sync_t;

	typedef struct packed {
		logic        awHeld;
		logic [31:0] awAddr;
		logic        wHeld;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] sampleWord;
		logic        ovForce;
	} asp_axil_st_t;

	typedef struct packed {
		logic        csPrev;
		logic        sclkPrev;
		logic        frameOpen;
		logic [4:0]  inCnt;
		logic [15:0] inShift;
		logic        cmdOk;
		logic        cmdRead;
		logic [21:0] outShift;
		logic [4:0]  outCnt;
		logic [4:0]  outLimit;
		logic        outEnN;
		asp_cfg_t    cfg;
		logic        lastCmdOk;
		logic        lastCmdRead;
		logic [15:0] accessCount;
	} asp_core_st_t;

endpackage : asp_pkg

// >>> asp_sync.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ns
module asp_sync
	import asp_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// Level from another domain, and its synchronised copy
	input  wire logic asyncIn,
	output logic      syncOut
);

	asp_sync_t st_reg;
	asp_sync_t st_next;

	always_comb begin
		st_next.stage1 = asyncIn;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_reg <= {RESET_VAL, RESET_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign syncOut = st_reg.stage2;

endmodule : asp_sync

// >>> asp_axil_slave.sv
// AXI4-Lite register slave: result word, overvoltage control, config and status readback
`timescale 1ns/1ns
`include "asp_defines.svh"
module asp_axil_slave
	import asp_pkg::*;
(
	// Clock and reset
	input  wire logic    core_clk,
	input  wire logic    sys_rst,
	// Register bus
	input  asp_axil_req_t axilReq,
	output asp_axil_rsp_t axilRsp,
	// Core state shown to software
	input  wire logic [7:0]  cfgByte,
	input  wire logic [31:0] statusWord,
	// Values software steers the core with
	output logic [15:0]      sampleWord,
	output logic             ovForce
);

	asp_axil_st_t st_reg;
	asp_axil_st_t st_next;
	logic         awReady;
	logic         wReady;
	logic         arReady;
	logic         haveAw;
	logic         haveW;
	logic [31:0]  addrW;
	logic [31:0]  dataW;
	logic [3:0]   strbW;

	// One write and one read in flight; a new one waits until the answer is taken
	assign awReady = !st_reg.awHeld && !st_reg.bvalid;
	assign wReady  = !st_reg.wHeld && !st_reg.bvalid;
	assign arReady = !st_reg.rvalid;
	assign haveAw  = st_reg.awHeld || (axilReq.awvalid && awReady);
	assign haveW   = st_reg.wHeld || (axilReq.wvalid && wReady);
	assign addrW   = st_reg.awHeld ? st_reg.awAddr : axilReq.awaddr;
	assign dataW   = st_reg.wHeld ? st_reg.wData : axilReq.wdata;
	assign strbW   = st_reg.wHeld ? st_reg.wStrb : axilReq.wstrb;

	always_comb begin
		st_next = st_reg;
		if (st_reg.bvalid && axilReq.bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.rvalid && axilReq.rready) begin
			st_next.rvalid = 1'b0;
		end
		if (axilReq.awvalid && awReady) begin
			st_next.awHeld = 1'b1;
			st_next.awAddr = axilReq.awaddr;
		end
		if (axilReq.wvalid && wReady) begin
			st_next.wHeld = 1'b1;
			st_next.wData = axilReq.wdata;
			st_next.wStrb = axilReq.wstrb;
		end
		if (haveAw && haveW) begin
			st_next.awHeld = 1'b0;
			st_next.wHeld  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = `ASP_RESP_OKAY;
			if (addrW == `ASP_OFF_RESULT) begin
				if (strbW[0]) begin
					st_next.sampleWord[7:0] = dataW[7:0];
				end
				if (strbW[1]) begin
					st_next.sampleWord[15:8] = dataW[15:8];
				end
			end else if (addrW == `ASP_OFF_CONTROL) begin
				if (strbW[0]) begin
					st_next.ovForce = dataW[0];
				end
			end else if (addrW == `ASP_OFF_CONFIG || addrW == `ASP_OFF_STATUS) begin
				st_next.bresp = `ASP_RESP_OKAY;
			end else begin
				st_next.bresp = `ASP_RESP_SLVERR;
			end
		end
		if (axilReq.arvalid && arReady) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = `ASP_RESP_OKAY;
			if (axilReq.araddr == `ASP_OFF_CONFIG) begin
				st_next.rdata = {24'h00_0000, cfgByte};
			end else if (axilReq.araddr == `ASP_OFF_RESULT) begin
				st_next.rdata = {16'h0000, st_reg.sampleWord};
			end else if (axilReq.araddr == `ASP_OFF_CONTROL) begin
				st_next.rdata = {31'h0000_0000, st_reg.ovForce};
			end else if (axilReq.araddr == `ASP_OFF_STATUS) begin
				st_next.rdata = statusWord;
			end else begin
				st_next.rdata = 32'h0000_0000;
				st_next.rresp = `ASP_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_reg            <= '0;
			st_reg.sampleWord <= `ASP_RESULT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign axilRsp.awready = awReady;
	assign axilRsp.wready  = wReady;
	assign axilRsp.bvalid  = st_reg.bvalid;
	assign axilRsp.bresp   = st_reg.bresp;
	assign axilRsp.arready = arReady;
	assign axilRsp.rvalid  = st_reg.rvalid;
	assign axilRsp.rdata   = st_reg.rdata;
	assign axilRsp.rresp   = st_reg.rresp;
	assign sampleWord      = st_reg.sampleWord;
	assign ovForce         = st_reg.ovForce;

endmodule : asp_axil_slave

// >>> asp_serial_port.sv
// Converter serial port: configuration register access, result and status shift-out
// Functional notes
// - Register access is 16 bits: command, data
// - Sample serial_input on serial clock rising edges
// - Change output on falling edges; float when deselected
// - Second command bit: one reads, zero writes
// - Command bits 5..0 must equal 010100
// - Write data MSB first; update after byte
// - Read shifts configuration byte out MSB first
// - Status enable appends six bits after result
// - Status MSB first, right after result LSB
// - Float output after the sixth status bit
// - Status: ov flag, span, high-Z, fast, reserved
// - Config bits 4..1 read/write, reset zero
// - Active-low sticky overvoltage flag, cleared by read
// - Writes to read-only config bits ignored
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "asp_defines.svh"
module asp_serial_port
	import asp_pkg::*;
(
	// Clock and reset
	input  wire logic     core_clk,
	input  wire logic     sys_rst,
	// Register bus
	input  asp_axil_req_t axilReq,
	output asp_axil_rsp_t axilRsp,
	// Serial link pins from the host
	input  wire logic     convertSelect,
	input  wire logic     serialClock,
	input  wire logic     serialInput,
	// Serial output pin, enable low while driven
	output logic          serialOutput,
	output logic          serialOutputEn_n,
	// Overvoltage monitor, same clock domain
	input  wire logic     overvoltageDetect,
	// Configuration towards the converter core
	output logic          statusBitsEn,
	output logic          spanCompressEn,
	output logic          highZEn,
	output logic          fastReadoutEn
);

	asp_core_st_t st_reg;
	asp_core_st_t st_next;
	logic         csSync;
	logic         sclkSync;
	logic         sdiSync;
	logic         csFall;
	logic         csRise;
	logic         sclkRise;
	logic         sclkFall;
	logic         inFrame;
	logic [7:0]   cmdByte;
	logic         cmdValid;
	logic         decodeNow;
	logic         writeNow;
	logic         ovNow;
	logic [7:0]   cfgByte;
	logic [5:0]   statusBits;
	logic [31:0]  statusWord;
	logic [15:0]  sampleWord;
	logic         ovForce;

	asp_sync #(.RESET_VAL(1'b1)) u_syncCs (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.asyncIn  (convertSelect),
		.syncOut  (csSync)
	);

	asp_sync #(.RESET_VAL(1'b0)) u_syncSclk (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.asyncIn  (serialClock),
		.syncOut  (sclkSync)
	);

	asp_sync #(.RESET_VAL(1'b1)) u_syncSdi (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.asyncIn  (serialInput),
		.syncOut  (sdiSync)
	);

	asp_axil_slave u_regs (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.axilReq    (axilReq),
		.axilRsp    (axilRsp),
		.cfgByte    (cfgByte),
		.statusWord (statusWord),
		.sampleWord (sampleWord),
		.ovForce    (ovForce)
	);

	// Edges of the link pins, found on the synchronised copies only
	assign csFall    = st_reg.csPrev && !csSync;
	assign csRise    = !st_reg.csPrev && csSync;
	assign sclkRise  = !st_reg.sclkPrev && sclkSync;
	assign sclkFall  = st_reg.sclkPrev && !sclkSync;
	assign inFrame   = st_reg.frameOpen && !csRise && !csFall;

	// Command byte as it stands once the eighth bit arrives
	assign cmdByte   = {st_reg.inShift[6:0], sdiSync};
	assign cmdValid  = !cmdByte[7] && (cmdByte[5:0] == `ASP_CMD_PATTERN);
	assign decodeNow = inFrame && sclkRise && (st_reg.inCnt == `ASP_CMD_LAST);
	assign writeNow  = inFrame && sclkRise && (st_reg.inCnt == `ASP_DATA_LAST)
		&& st_reg.cmdOk && !st_reg.cmdRead;

	assign ovNow      = overvoltageDetect || ovForce;
	assign cfgByte    = st_reg.cfg;
	assign statusBits = {st_reg.cfg.ovFlagN, st_reg.cfg.spanComp, st_reg.cfg.highZ,
		st_reg.cfg.fastRead, 2'h0};
	assign statusWord = {8'h00, st_reg.accessCount, 5'h00, st_reg.lastCmdRead,
		st_reg.lastCmdOk, st_reg.frameOpen};

	always_comb begin
		st_next          = st_reg;
		st_next.csPrev   = csSync;
		st_next.sclkPrev = sclkSync;
		if (csRise) begin
			// Deselect ends the frame and floats the output at once
			st_next.frameOpen = 1'b0;
			st_next.outEnN    = 1'b1;
		end else if (csFall) begin
			st_next.frameOpen = 1'b1;
			st_next.inCnt     = 5'h00;
			st_next.cmdOk     = 1'b0;
			st_next.cmdRead   = 1'b0;
			// Result MSB appears with the select edge, status already appended
			st_next.outShift  = {sampleWord, statusBits};
			st_next.outCnt    = 5'h00;
			st_next.outLimit  = st_reg.cfg.statusEn ? `ASP_RESULT_STATUS
				: `ASP_RESULT_BITS;
			st_next.outEnN    = 1'b0;
		end else if (st_reg.frameOpen) begin
			if (sclkRise && st_reg.inCnt < `ASP_IN_BITS) begin
				st_next.inShift = {st_reg.inShift[14:0], sdiSync};
				st_next.inCnt   = 5'(st_reg.inCnt + 5'h01);
			end
			if (decodeNow) begin
				st_next.cmdOk       = cmdValid;
				st_next.cmdRead     = cmdValid && cmdByte[6];
				st_next.lastCmdOk   = cmdValid;
				st_next.lastCmdRead = cmdValid && cmdByte[6];
				if (cmdValid) begin
					st_next.accessCount = 16'(st_reg.accessCount + 16'h0001);
				end
				if (cmdValid && cmdByte[6]) begin
					// Seven bits already left; the next falling edge shows bit 7
					st_next.outShift[20:13] = cfgByte;
					if (!ovNow) begin
						st_next.cfg.ovFlagN = 1'b1;
					end
				end
			end
			if (writeNow) begin
				// Only the read/write fields take the byte; bit 0 and 7..5 stay
				st_next.cfg.statusEn = st_reg.inShift[3];
				st_next.cfg.spanComp = st_reg.inShift[2];
				st_next.cfg.highZ    = st_reg.inShift[1];
				st_next.cfg.fastRead = st_reg.inShift[0];
			end
			if (sclkFall && !st_reg.outEnN) begin
				st_next.outShift = {st_reg.outShift[20:0], 1'b0};
				st_next.outCnt   = 5'(st_reg.outCnt + 5'h01);
				if (5'(st_reg.outCnt + 5'h01) == st_reg.outLimit) begin
					st_next.outEnN = 1'b1;
				end
			end
		end
		// A live overvoltage condition wins over the read that clears the flag
		if (ovNow) begin
			st_next.cfg.ovFlagN = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_reg          <= '0;
			st_reg.csPrev   <= 1'b1;
			st_reg.outEnN   <= 1'b1;
			st_reg.outLimit <= `ASP_RESULT_BITS;
			st_reg.cfg      <= `ASP_CFG_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign serialOutput     = st_reg.outShift[21];
	assign serialOutputEn_n = st_reg.outEnN;
	assign statusBitsEn     = st_reg.cfg.statusEn;
	assign spanCompressEn   = st_reg.cfg.spanComp;
	assign highZEn          = st_reg.cfg.highZ;
	assign fastReadoutEn    = st_reg.cfg.fastRead;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_float_on_deselect;
		csRise |=> serialOutputEn_n;
	endproperty
	a_float_on_deselect: assert property (p_float_on_deselect)
		else $error("output still driven after deselect");

	property p_msb_on_select;
		csFall |=> !serialOutputEn_n && (serialOutput == $past(sampleWord[15]));
	endproperty
	a_msb_on_select: assert property (p_msb_on_select)
		else $error("result MSB not driven at select");

	property p_shift_on_fall;
		(inFrame && sclkFall && !serialOutputEn_n)
			|=> (serialOutput == $past(st_reg.outShift[20]));
	endproperty
	a_shift_on_fall: assert property (p_shift_on_fall)
		else $error("output did not advance on falling edge");

	property p_status_length;
		csFall |=> (st_reg.outLimit == ($past(st_reg.cfg.statusEn) ? 5'h16 : 5'h10));
	endproperty
	a_status_length: assert property (p_status_length)
		else $error("wrong output length for status setting");

	property p_float_after_last;
		(st_reg.frameOpen && st_reg.outCnt == st_reg.outLimit) |-> serialOutputEn_n;
	endproperty
	a_float_after_last: assert property (p_float_after_last)
		else $error("output driven after last bit");

	property p_sample_rise;
		(inFrame && sclkRise && st_reg.inCnt < 5'h10)
			|=> (st_reg.inCnt == $past(st_reg.inCnt) + 5'h01)
			&& (st_reg.inShift[0] == $past(sdiSync));
	endproperty
	a_sample_rise: assert property (p_sample_rise)
		else $error("input bit not taken on rising edge");

	property p_read_data;
		(decodeNow && cmdValid && cmdByte[6])
			|=> (st_reg.outShift[20:13] == $past(cfgByte)) && st_reg.cmdRead;
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("config byte not loaded for read");

	property p_write_update;
		writeNow |=> (st_reg.cfg[4:1] == $past(st_reg.inShift[3:0]));
	endproperty
	a_write_update: assert property (p_write_update)
		else $error("write did not update config fields");

	property p_bad_command;
		(decodeNow && !cmdValid) |=> !st_reg.cmdOk ##1 $stable(st_reg.cfg[4:1]);
	endproperty
	a_bad_command: assert property (p_bad_command)
		else $error("bad command changed configuration");

	property p_reserved_zero;
		st_reg.cfg.reserved == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved config bits not zero");

	property p_ov_sets;
		ovNow |=> !st_reg.cfg.ovFlagN;
	endproperty
	a_ov_sets: assert property (p_ov_sets)
		else $error("overvoltage flag not set");

	property p_ov_sticky;
		(!st_reg.cfg.ovFlagN && !(decodeNow && cmdValid && cmdByte[6]))
			|=> !st_reg.cfg.ovFlagN;
	endproperty
	a_ov_sticky: assert property (p_ov_sticky)
		else $error("overvoltage flag cleared without read");

	property p_open_on_select;
		csFall |=> st_reg.frameOpen && (st_reg.inCnt == 5'h00) && !st_reg.cmdOk;
	endproperty
	a_open_on_select: assert property (p_open_on_select)
		else $error("frame not opened at select");

	property p_out_count;
		(inFrame && sclkFall && !serialOutputEn_n)
			|=> (st_reg.outCnt == $past(st_reg.outCnt) + 5'h01);
	endproperty
	a_out_count: assert property (p_out_count)
		else $error("output bit count did not advance");

	property p_out_idle;
		(!st_reg.frameOpen && !csFall) |=> $stable(st_reg.outShift);
	endproperty
	a_out_idle: assert property (p_out_idle)
		else $error("output shifted outside a frame");

	property p_float_outside;
		!st_reg.frameOpen |-> serialOutputEn_n;
	endproperty
	a_float_outside: assert property (p_float_outside)
		else $error("output driven outside a frame");

	property p_in_idle;
		(!st_reg.frameOpen && !csFall) |=> $stable(st_reg.inShift);
	endproperty
	a_in_idle: assert property (p_in_idle)
		else $error("input sampled outside a frame");

	property p_drive_until_last;
		(st_reg.frameOpen && (st_reg.outCnt < st_reg.outLimit)) |-> !serialOutputEn_n;
	endproperty
	a_drive_until_last: assert property (p_drive_until_last)
		else $error("output floated before its last bit");

	property p_status_map;
		csFall |=> (st_reg.outShift[5:0] == {$past(st_reg.cfg[0]), $past(st_reg.cfg[3:1]), 2'b00});
	endproperty
	a_status_map: assert property (p_status_map)
		else $error("status bits do not mirror configuration");

	property p_ov_read_clear;
		(decodeNow && cmdValid && cmdByte[6] && !ovNow) |=> st_reg.cfg.ovFlagN;
	endproperty
	a_ov_read_clear: assert property (p_ov_read_clear)
		else $error("overvoltage flag not cleared by read");

	property p_write_keeps_flag;
		(writeNow && !ovNow) |=> (st_reg.cfg.ovFlagN == $past(st_reg.cfg.ovFlagN));
	endproperty
	a_write_keeps_flag: assert property (p_write_keeps_flag)
		else $error("write changed the read-only flag");

	property p_no_write_without_cmd;
		!(st_reg.cmdOk && !st_reg.cmdRead) |=> $stable(st_reg.cfg[4:1]);
	endproperty
	a_no_write_without_cmd: assert property (p_no_write_without_cmd)
		else $error("configuration changed without a valid write");

endmodule : asp_serial_port

// >>> asp_host_model.sv
// Host model: serial master that frames register accesses and reads result words
`timescale 1ns/1ns
module asp_host_model (
	// Serial link pins towards the port
	output logic      convertSelect,
	output logic      serialClock,
	output logic      serialInput,
	// Output pin of the port, enable low while driven
	input  wire logic serialOutput,
	input  wire logic serialOutputEn_n
);
	// Slow link: conversion throughput is not modelled, so the rate minimums are not reached
	localparam int HALF = 40;
	logic lastLevel;
	logic lineLevel;
	// A released output shows the inverse of the last level, so a float never reads as data
	assign lineLevel = serialOutputEn_n ? ~lastLevel : serialOutput;
	initial begin
		convertSelect = 1'b1;
		serialClock   = 1'b0;
		serialInput   = 1'b1;
		lastLevel     = 1'b0;
	end
	// Bits go out MSB first from din[21]; a short count stops the frame early
	task automatic xfer(input int nBits, input logic [21:0] din, output logic [21:0] dout,
		output logic [21:0] drv, output logic endEn_n);
		dout = '0;
		drv = '1;
		// Pins change by non-blocking assignment, so a coinciding core clock edge sees old levels
		convertSelect <= 1'b0;
		#(2*HALF);
		for (int i = 0; i < nBits; i++) begin
			serialInput <= din[21-i];
			#HALF;
			serialClock <= 1'b1;
			dout[21-i] = lineLevel;
			drv[21-i] = serialOutputEn_n;
			lastLevel = lineLevel;
			#HALF;
			serialClock <= 1'b0;
		end
		#HALF;
		endEn_n = serialOutputEn_n;
		serialInput <= 1'b1;
		convertSelect <= 1'b1;
		#(2*HALF);
	endtask : xfer
endmodule : asp_host_model

// >>> tb_top.sv
// Testbench for the serial port: register bus, register access frames and status bits
`timescale 1ns/1ns
`include "asp_defines.svh"
module tb_top
	import asp_pkg::*;
;
	logic          core_clk;
	logic          sys_rst;
	asp_axil_req_t axilReq;
	asp_axil_rsp_t axilRsp;
	logic          convertSelect;
	logic          serialClock;
	logic          serialInput;
	logic          serialOutput;
	logic          serialOutputEn_n;
	logic          overvoltageDetect;
	logic          statusBitsEn;
	logic          spanCompressEn;
	logic          highZEn;
	logic          fastReadoutEn;
	logic [31:0]   enables;
	logic [21:0]   dout;
	logic [21:0]   drv;
	logic          endEn_n;
	logic [31:0]   rd;
	logic [1:0]    resp;
	int            miscompares;
	int            nTests;
	int            cycles;

	assign enables = {28'h000_0000, statusBitsEn, spanCompressEn, highZEn, fastReadoutEn};

	asp_serial_port dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .axilReq(axilReq), .axilRsp(axilRsp),
		.convertSelect(convertSelect), .serialClock(serialClock), .serialInput(serialInput),
		.serialOutput(serialOutput), .serialOutputEn_n(serialOutputEn_n),
		.overvoltageDetect(overvoltageDetect), .statusBitsEn(statusBitsEn),
		.spanCompressEn(spanCompressEn), .highZEn(highZEn), .fastReadoutEn(fastReadoutEn)
	);

	asp_host_model host (
		.convertSelect(convertSelect), .serialClock(serialClock), .serialInput(serialInput),
		.serialOutput(serialOutput), .serialOutputEn_n(serialOutputEn_n)
	);

	always #4 core_clk = ~core_clk;

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	// Ceiling well above the roughly 2800 cycles the scenarios need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge core_clk);
		axilReq.awvalid <= 1'b1;
		axilReq.awaddr  <= addr;
		axilReq.wvalid  <= 1'b1;
		axilReq.wdata   <= data;
		axilReq.wstrb   <= 4'hF;
		axilReq.bready  <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (axilReq.awvalid && axilRsp.awready) axilReq.awvalid <= 1'b0;
			if (axilReq.wvalid && axilRsp.wready) axilReq.wvalid <= 1'b0;
			if (axilReq.bready && axilRsp.bvalid) begin
				r = axilRsp.bresp;
				axilReq.bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_write

	task automatic axi_read(input logic [31:0] addr, output logic [31:0] d,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge core_clk);
		axilReq.arvalid <= 1'b1;
		axilReq.araddr  <= addr;
		axilReq.rready  <= 1'b1;
		while (!done) begin
			@(posedge core_clk);
			if (axilReq.arvalid && axilRsp.arready) axilReq.arvalid <= 1'b0;
			if (axilReq.rready && axilRsp.rvalid) begin
				d = axilRsp.rdata;
				r = axilRsp.rresp;
				axilReq.rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_read

	task automatic frame16(input logic [7:0] cmd, input logic [7:0] data);
		host.xfer(16, {cmd, data, 6'h3F}, dout, drv, endEn_n);
	endtask : frame16

	task automatic test_reset();
		axi_read(`ASP_OFF_CONFIG, rd, resp);
		chk(rd, 32'h0000_0001);
		chk(enables, 32'h0000_0000);
		axi_read(32'h0000_0010, rd, resp);
		chk({30'h0, resp}, {30'h0, `ASP_RESP_SLVERR});
		axi_write(`ASP_OFF_CONFIG, 32'h0000_00FF, resp);
		axi_read(`ASP_OFF_CONFIG, rd, resp);
		chk(rd, 32'h0000_0001);
		axi_write(`ASP_OFF_RESULT, 32'h0000_A5C3, resp);
		chk({30'h0, resp}, {30'h0, `ASP_RESP_OKAY});
	endtask : test_reset

	// Not a register command: the result goes out alone and the pin floats after 16 bits
	task automatic test_result_frame();
		frame16(8'hFF, 8'hFF);
		chk({16'h0, dout[21:6]}, 32'h0000_A5C3);
		chk({10'h0, drv}, {26'h0, 6'h3F});
		chk({31'h0, endEn_n}, 32'h0000_0001);
		chk(enables, 32'h0000_0000);
	endtask : test_result_frame

	task automatic test_config_write();
		logic [7:0] vals [6];
		vals = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'hFE};
		foreach (vals[i]) begin
			frame16(8'h14, vals[i]);
			chk(enables, {28'h0, vals[i][4:1]});
			axi_read(`ASP_OFF_CONFIG, rd, resp);
			chk(rd, {24'h0, 3'b000, vals[i][4:1], 1'b1});
		end
	endtask : test_config_write

	task automatic test_status_bits();
		host.xfer(22, 22'h3F_FFFF, dout, drv, endEn_n);
		chk({10'h0, dout}, {10'h0, 16'hA5C3, 6'b111100});
		chk({10'h0, drv}, 32'h0000_0000);
		chk({31'h0, endEn_n}, 32'h0000_0001);
	endtask : test_status_bits

	// Read stops before the status bits, so the float must come from the deselect edge
	task automatic test_config_read();
		frame16(8'h54, 8'hFF);
		chk({24'h0, dout[21:14]}, 32'h0000_00A5);
		chk({24'h0, dout[13:6]}, 32'h0000_001F);
		chk({31'h0, endEn_n}, 32'h0000_0000);
		chk({31'h0, serialOutputEn_n}, 32'h0000_0001);
		chk(enables, 32'h0000_000F);
	endtask : test_config_read

	task automatic test_bad_command();
		logic [7:0] cmds [3];
		cmds = '{8'h15, 8'h94, 8'h34};
		foreach (cmds[i]) begin
			frame16(cmds[i], 8'h00);
			chk({24'h0, dout[13:6]}, 32'h0000_00C3);
			chk(enables, 32'h0000_000F);
		end
	endtask : test_bad_command

	task automatic test_overvoltage();
		@(posedge core_clk);
		overvoltageDetect <= 1'b1;
		repeat (2) @(posedge core_clk);
		overvoltageDetect <= 1'b0;
		axi_read(`ASP_OFF_CONFIG, rd, resp);
		chk(rd, 32'h0000_001E);
		frame16(8'h54, 8'hFF);
		chk({24'h0, dout[13:6]}, 32'h0000_001E);
		axi_read(`ASP_OFF_CONFIG, rd, resp);
		chk(rd, 32'h0000_001F);
	endtask : test_overvoltage

	// Eight valid commands so far, the last a read; forced condition must stick after release
	task automatic test_control_status();
		axi_read(`ASP_OFF_STATUS, rd, resp);
		chk(rd, 32'h0000_0806);
		axi_read(`ASP_OFF_RESULT, rd, resp);
		chk(rd, 32'h0000_A5C3);
		axi_write(`ASP_OFF_CONTROL, 32'h0000_0001, resp);
		axi_read(`ASP_OFF_CONTROL, rd, resp);
		chk(rd, 32'h0000_0001);
		axi_write(`ASP_OFF_CONTROL, 32'h0000_0000, resp);
		axi_read(`ASP_OFF_CONFIG, rd, resp);
		chk(rd, 32'h0000_001E);
		host.xfer(22, 22'h3F_FFFF, dout, drv, endEn_n);
		chk({26'h0, dout[5:0]}, {26'h0, 6'b011100});
		axi_write(32'h0000_0020, 32'h0000_0000, resp);
		chk({30'h0, resp}, {30'h0, `ASP_RESP_SLVERR});
	endtask : test_control_status

	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		axilReq = '0;
		overvoltageDetect = 1'b0;
		miscompares = 0;
		nTests = 0;
		cycles = 0;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		test_reset();
		test_result_frame();
		test_config_write();
		test_status_bits();
		test_config_read();
		test_bad_command();
		test_overvoltage();
		test_control_status();
		finish_test();
	end
endmodule : tb_top
